//--- rtl/mcd_ctrl.sv
/*
  Settings controller of a calibration source: divider, main level,
  deviation with presets, output on/off and output frequency.
  Assumes a plain register port, synchronous inputs, and a sweep engine
  that pulses sweep_step at the sweep rate.
*/
module mcd_ctrl #(
  parameter int REFRESH_CYC = mcd_pkg::REFRESH_CYC,
  parameter logic [7:0] ERR_CODE = 8'h5a // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Retained storage and events
  input wire logic [3:0] den_stored,
  input wire logic ovl_det,
  input wire logic sweep_step,
  // Indicators and results
  output logic [3:0] den_save,
  output logic out_on,
  output logic led_on,
  output logic led_off,
  output logic beep_req,
  output logic blink,
  output logic [19:0] disp_freq,
  output logic err_flag,
  output logic [7:0] err_code
);
  localparam int RW = $clog2(REFRESH_CYC + 1);
  localparam logic [RW-1:0] REF_LAST = RW'(REFRESH_CYC - 1);

  mcd_pkg::mcd_div_t div;
  mcd_pkg::mcd_meter_t met;
  mcd_pkg::mcd_preset_t preset;
  mcd_pkg::mcd_preset_t next_preset;
  mcd_pkg::mcd_sweep_t sweep;
  logic [13:0] level;
  logic [13:0] next_level;
  logic signed [15:0] dev;
  logic signed [15:0] wdev;
  logic signed [31:0] freq;
  logic [3:0] range;
  logic [RW-1:0] ref_cnt;
  logic beep_en;
  logic init_done;
  logic next_out;

  // Write decode
  logic w_den, w_num, w_lvl, w_fmin, w_fmax, w_dev, w_pset, w_psw;
  logic w_ctrl, w_sweep, w_range;
  assign w_den = wr && addr == mcd_pkg::A_DEN;
  assign w_num = wr && addr == mcd_pkg::A_NUM;
  assign w_lvl = wr && addr == mcd_pkg::A_LVL;
  assign w_fmin = wr && addr == mcd_pkg::A_FMIN;
  assign w_fmax = wr && addr == mcd_pkg::A_FMAX;
  assign w_dev = wr && addr == mcd_pkg::A_DEV;
  assign w_pset = wr && addr == mcd_pkg::A_PSET;
  assign w_psw = wr && addr == mcd_pkg::A_PSW;
  assign w_ctrl = wr && addr == mcd_pkg::A_CTRL;
  assign w_sweep = wr && addr == mcd_pkg::A_SWEEP;
  assign w_range = wr && addr == mcd_pkg::A_RANGE;

  // Accepted changes
  logic den_chg, num_chg, num_up, met_chg, fmin_ok, fmax_ok;
  logic dev_ok, pset_chg, psw_up, psw_dn, range_chg, toggle, sw_hold;
  assign sw_hold = sweep == mcd_pkg::SW_HOLD;
  assign den_chg = w_den && wdata >= {28'h0000000, mcd_pkg::DEN_MIN}
                   && wdata <= {28'h0000000, mcd_pkg::DEN_MAX};
  assign num_chg = w_num && wdata <= {28'h0000000, div.den}
                   && wdata[3:0] != div.num;
  assign num_up = wdata[3:0] > div.num;
  assign fmin_ok = w_fmin && wdata <= {12'h000, met.fmax};
  assign fmax_ok = w_fmax && wdata >= {12'h000, met.fmin}
                   && wdata <= {12'h000, mcd_pkg::F_HI};
  assign met_chg = fmin_ok || fmax_ok;
  assign wdev = wdata[15:0];
  assign dev_ok = w_dev && sw_hold
                  && wdev >= mcd_pkg::DEV_MIN && wdev <= mcd_pkg::DEV_MAX
                  && mcd_pkg::calc_freq(met, div, wdev)
                     < $signed({12'h000, mcd_pkg::F_HI});
  assign pset_chg = w_pset && sw_hold
                    && wdata[1:0] != preset;
  assign psw_up = w_psw && sw_hold && wdata[mcd_pkg::PSW_UP];
  assign psw_dn = w_psw && sw_hold && wdata[mcd_pkg::PSW_DN];
  assign range_chg = w_range && wdata[3:0] != range;
  assign toggle = w_ctrl && wdata[mcd_pkg::CTL_TOGGLE];
  assign next_level = wdata > {18'h0, mcd_pkg::LVL_MAX} ?
                      mcd_pkg::LVL_MAX : wdata[13:0];

  // Preset switch steps OFF, 0, 2, 5
  always_comb begin
    next_preset = preset;
    if (pset_chg) begin
      next_preset = mcd_pkg::mcd_preset_t'(wdata[1:0]);
    end else if (psw_up && preset != mcd_pkg::PS_5) begin
      next_preset = mcd_pkg::mcd_preset_t'(preset + 2'h1);
    end else if (psw_dn && preset != mcd_pkg::PS_OFF) begin
      next_preset = mcd_pkg::mcd_preset_t'(preset - 2'h1);
    end
  end

  // Sweep stop and advance
  logic sw_stop, sw_adv;
  assign sw_stop = (sweep == mcd_pkg::SW_UP && (dev <= mcd_pkg::DEV_MIN
                    || freq >= $signed({12'h000, mcd_pkg::F_HI})))
                   || (sweep == mcd_pkg::SW_DOWN && (dev >= mcd_pkg::DEV_MAX
                    || freq <= $signed({12'h000, mcd_pkg::F_LO})));
  assign sw_adv = sweep_step && !sw_hold && !sw_stop;

  // Divider, with power-up restore
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_done <= 1'b0;
      div <= {mcd_pkg::DEN_RST, mcd_pkg::DEN_RST};
    end else if (ce) begin
      if (!init_done) begin
        init_done <= 1'b1;
        if (den_stored >= mcd_pkg::DEN_MIN) begin
          div <= {den_stored, den_stored};
        end
      end else if (den_chg) begin
        div <= {wdata[3:0], wdata[3:0]};
      end else if (num_chg) begin
        div.num <= wdata[3:0];
      end
    end
  end
  assign den_save = div.den;

  // Main level, meter limits, range, beep enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= '0;
      met <= {mcd_pkg::FMIN_RST, mcd_pkg::FMAX_RST};
      range <= '0;
      beep_en <= 1'b1;
    end else if (ce) begin
      if (w_lvl) begin
        level <= next_level;
      end
      if (fmin_ok) begin
        met.fmin <= wdata[19:0];
      end
      if (fmax_ok) begin
        met.fmax <= wdata[19:0];
      end
      if (w_range) begin
        range <= wdata[3:0];
      end
      if (w_ctrl) begin
        beep_en <= wdata[mcd_pkg::CTL_BEEP];
      end
    end
  end

  // Deviation
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dev <= mcd_pkg::DEV_ZERO;
    end else if (ce) begin
      if (sw_adv) begin
        dev <= sweep == mcd_pkg::SW_UP ? dev - mcd_pkg::DEV_ONE
                                        : dev + mcd_pkg::DEV_ONE;
      end else if (den_chg || w_lvl || met_chg) begin
        dev <= mcd_pkg::DEV_ZERO;
      end else if (num_chg) begin
        if (preset != mcd_pkg::PS_OFF) begin
          dev <= mcd_pkg::preset_dev(preset, num_up);
        end
      end else if (dev_ok) begin
        dev <= wdev;
      end else if (psw_dn && preset == mcd_pkg::PS_OFF) begin
        dev <= mcd_pkg::DEV_ZERO;
      end else if (next_preset != preset && next_preset != mcd_pkg::PS_OFF) begin
        dev <= mcd_pkg::preset_dev(next_preset, 1'b1);
      end
    end
  end

  // Preset selection
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      preset <= mcd_pkg::PS_0;
    end else if (ce) begin
      preset <= next_preset;
    end
  end

  // Sweep direction
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sweep <= mcd_pkg::SW_HOLD;
    end else if (ce) begin
      if (sw_stop || w_lvl || met_chg) begin
        sweep <= mcd_pkg::SW_HOLD;
      end else if (w_sweep) begin
        unique case (wdata[1:0])
          2'h1: sweep <= mcd_pkg::SW_UP;
          2'h2: sweep <= mcd_pkg::SW_DOWN;
          default: sweep <= mcd_pkg::SW_HOLD;
        endcase
      end
    end
  end

  // Output state and indicators
  always_comb begin
    next_out = out_on;
    if (ovl_det || range_chg) begin
      next_out = 1'b0;
    end else if (toggle) begin
      next_out = !out_on;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_on <= 1'b0;
      led_on <= 1'b0;
      led_off <= 1'b1;
    end else if (ce) begin
      out_on <= next_out;
      led_on <= next_out;
      led_off <= !next_out;
    end
  end

  // Overload error latch, set wins over clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_flag <= 1'b0;
      err_code <= '0;
    end else if (ce) begin
      if (ovl_det) begin
        err_flag <= 1'b1;
        err_code <= ERR_CODE;
      end else if (w_ctrl && wdata[mcd_pkg::CTL_ERRCLR]) begin
        err_flag <= 1'b0;
        err_code <= '0;
      end
    end
  end

  // Beep on high voltage level or sweep stop
  logic [39:0] lvl_mv;
  assign lvl_mv = 40'(next_level) * 40'(mcd_pkg::rating_mv(range[2:0]));
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      beep_req <= 1'b0;
    end else if (ce) begin
      beep_req <= beep_en && ((w_lvl && !range[mcd_pkg::RANGE_CUR]
                  && lvl_mv >= mcd_pkg::BEEP_LIM) || sw_stop);
    end
  end

  // Output frequency and blink
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq <= '0;
      blink <= 1'b0;
    end else if (ce) begin
      freq <= mcd_pkg::calc_freq(met, div, dev);
      blink <= freq >= $signed({12'h000, mcd_pkg::F_HI})
               || freq < $signed({12'h000, mcd_pkg::F_LO});
    end
  end

  // Display refresh while output is on
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt <= '0;
      disp_freq <= '0;
    end else if (ce) begin
      if (!out_on) begin
        ref_cnt <= '0;
      end else if (ref_cnt == REF_LAST) begin
        ref_cnt <= '0;
        disp_freq <= freq[19:0];
      end else begin
        ref_cnt <= ref_cnt + RW'(1);
      end
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          mcd_pkg::A_DEN: rdata <= {28'h0000000, div.den};
          mcd_pkg::A_NUM: rdata <= {28'h0000000, div.num};
          mcd_pkg::A_LVL: rdata <= {18'h0, level};
          mcd_pkg::A_FMIN: rdata <= {12'h000, met.fmin};
          mcd_pkg::A_FMAX: rdata <= {12'h000, met.fmax};
          mcd_pkg::A_DEV: rdata <= 32'(dev);
          mcd_pkg::A_PSET: rdata <= {30'h0, preset};
          mcd_pkg::A_CTRL: rdata <= {30'h0, beep_en, 1'b0};
          mcd_pkg::A_SWEEP: rdata <= {30'h0, sweep};
          mcd_pkg::A_RANGE: rdata <= {28'h0000000, range};
          mcd_pkg::A_STAT: rdata <= {27'h0, sweep, blink, err_flag, out_on};
          mcd_pkg::A_FOUT: rdata <= freq;
          default: rdata <= '0;
        endcase
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_den_range:
    assert property (div.den >= mcd_pkg::DEN_MIN)
      else $error("denominator below minimum");
  chk_num_le_den:
    assert property (div.num <= div.den)
      else $error("numerator above denominator");
  chk_den_loads_num:
    assert property (ce && init_done && den_chg |=> div.num == $past(wdata[3:0])
                     && div.den == $past(wdata[3:0]))
      else $error("denominator write did not load numerator");
  chk_level_clamp:
    assert property (level <= mcd_pkg::LVL_MAX)
      else $error("level above 120 percent");
  chk_leds_follow:
    assert property (led_on == out_on && led_off == !out_on)
      else $error("indicators disagree with output");
  chk_range_off:
    assert property (ce && range_chg |=> !out_on && !led_on)
      else $error("range change left output on");
  chk_ovl_off:
    assert property (ce && ovl_det |=> !out_on && err_flag && err_code == ERR_CODE)
      else $error("overload not handled");
  chk_dev_range:
    assert property (dev >= mcd_pkg::DEV_MIN && dev <= mcd_pkg::DEV_MAX)
      else $error("deviation out of range");
  chk_sweep_preset:
    assert property (!sw_hold ##1 !sw_hold |-> $stable(preset))
      else $error("preset changed during sweep");
  chk_clear_dev:
    assert property (ce && !sw_adv && (w_lvl || met_chg) |=> dev == mcd_pkg::DEV_ZERO)
      else $error("deviation not cleared");
endmodule : mcd_ctrl

//--- rtl/mcd_pkg.sv
/*
  Constants, types and the frequency arithmetic shared by the calibration
  divider and deviation controller. Assumes a 125 MHz core clock.
*/
package mcd_pkg;
  // Clock and display refresh
  localparam int CLK_HZ = 125_000_000;
  localparam int REFRESH_MS = 200;
  localparam int REFRESH_CYC = CLK_HZ / 1000 * REFRESH_MS;

  // Register byte offsets
  localparam logic [7:0] A_DEN = 8'h00;
  localparam logic [7:0] A_NUM = 8'h04;
  localparam logic [7:0] A_LVL = 8'h08;
  localparam logic [7:0] A_FMIN = 8'h0c;
  localparam logic [7:0] A_FMAX = 8'h10;
  localparam logic [7:0] A_DEV = 8'h14;
  localparam logic [7:0] A_PSET = 8'h18;
  localparam logic [7:0] A_PSW = 8'h1c;
  localparam logic [7:0] A_CTRL = 8'h20;
  localparam logic [7:0] A_SWEEP = 8'h24;
  localparam logic [7:0] A_RANGE = 8'h28;
  localparam logic [7:0] A_STAT = 8'h2c;
  localparam logic [7:0] A_FOUT = 8'h30;

  // Field positions
  localparam int CTL_TOGGLE = 0;
  localparam int CTL_BEEP = 1;
  localparam int CTL_ERRCLR = 2;
  localparam int PSW_UP = 0;
  localparam int PSW_DN = 1;
  localparam int RANGE_CUR = 3;

  // Divider limits and reset values
  localparam logic [3:0] DEN_MIN = 4'h4;
  localparam logic [3:0] DEN_MAX = 4'hf;
  localparam logic [3:0] DEN_RST = 4'h4;

  // Main level in 0.01 % of range rating
  localparam logic [13:0] LVL_MAX = 14'h2ee0;
  localparam logic [39:0] BEEP_LIM = 40'h0059682f00;

  // Deviation in 0.01 % steps
  localparam logic signed [15:0] DEV_MAX = 16'sh07d0;
  localparam logic signed [15:0] DEV_MIN = -16'sh07d0;
  localparam logic signed [15:0] DEV_ZERO = 16'sh0000;
  localparam logic signed [15:0] DEV_ONE = 16'sh0001;
  localparam logic signed [15:0] DEV_P2 = 16'sh00c8;
  localparam logic signed [15:0] DEV_P5 = 16'sh01f4;
  localparam logic signed [31:0] DEV_SCALE = 32'sh00002710;

  // Frequencies in mHz
  localparam logic [19:0] F_HI = 20'hf4240;
  localparam logic [19:0] F_LO = 20'h04e20;
  localparam logic [19:0] FMIN_RST = 20'h0afc8;
  localparam logic [19:0] FMAX_RST = 20'h0fde8;

  typedef enum logic [1:0] {PS_OFF, PS_0, PS_2, PS_5} mcd_preset_t;
  typedef enum logic [1:0] {SW_HOLD, SW_UP, SW_DOWN} mcd_sweep_t;

  typedef struct packed {
    logic [3:0] den;
    logic [3:0] num;
  } mcd_div_t;

  typedef struct packed {
    logic [19:0] fmin;
    logic [19:0] fmax;
  } mcd_meter_t;

  // Span x n/m + min - span x deviation, in mHz
  function automatic logic signed [31:0] calc_freq(mcd_meter_t m, mcd_div_t d,
                                                   logic signed [15:0] dv);
    logic signed [31:0] sp;
    logic signed [31:0] a;
    logic signed [31:0] b;
    sp = $signed({12'h000, m.fmax}) - $signed({12'h000, m.fmin});
    a = (sp * $signed({28'h0000000, d.num})) / $signed({28'h0000000, d.den});
    b = (sp * 32'(dv)) / DEV_SCALE;
    return a + $signed({12'h000, m.fmin}) - b;
  endfunction : calc_freq

  // Rating of a voltage range in mV
  function automatic logic [19:0] rating_mv(logic [2:0] idx);
    case (idx)
      3'h0: rating_mv = 20'h00064;
      3'h1: rating_mv = 20'h003e8;
      3'h2: rating_mv = 20'h02710;
      3'h3: rating_mv = 20'h186a0;
      3'h4: rating_mv = 20'h493e0;
      default: rating_mv = 20'hf4240;
    endcase
  endfunction : rating_mv

  // Deviation a preset loads; sign follows direction
  function automatic logic signed [15:0] preset_dev(mcd_preset_t p, logic up);
    logic signed [15:0] v;
    v = DEV_ZERO;
    if (p == PS_2) begin
      v = DEV_P2;
    end else if (p == PS_5) begin
      v = DEV_P5;
    end
    return up ? v : -v;
  endfunction : preset_dev
endpackage : mcd_pkg

//--- verification/mcd_ctrl_test.sv
/*
  Self-checking bench of the divider and deviation controller.
  Assumes the panel model drives the register port; overload and sweep
  pulses come from here. Refresh count shortened to 8 cycles.
*/
module mcd_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ERR = 8'h3c; // Arbitrary value
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [3:0] den_stored = 4'h9;
  logic ovl_det = 1'b0;
  logic sweep_step = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [3:0] den_save;
  logic out_on;
  logic led_on;
  logic led_off;
  logic beep_req;
  logic blink;
  logic [19:0] disp_freq;
  logic err_flag;
  logic [7:0] err_code;
  int err_count = 0;
  int n_checks = 0;
  int den;
  int num;
  int dv;

  always #4 core_clk = ~core_clk;

  mcd_panel P (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  mcd_ctrl #(.REFRESH_CYC(8), .ERR_CODE(ERR)) DUT (.core_clk(core_clk), .rst_b(rst_b),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .den_stored(den_stored), .ovl_det(ovl_det), .sweep_step(sweep_step),
    .den_save(den_save), .out_on(out_on), .led_on(led_on), .led_off(led_off),
    .beep_req(beep_req), .blink(blink), .disp_freq(disp_freq), .err_flag(err_flag),
    .err_code(err_code));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    P.rd_reg(a, d);
    chk_word(d, exp, what);
  endtask : rd_chk

  // Output state and both lamps, one settled cycle later
  task automatic lamps(input logic on);
    @(posedge core_clk);
    #1;
    chk_bit(out_on, on, "output state");
    chk_bit(led_on, on, "green lamp");
    chk_bit(led_off, !on, "red lamp");
  endtask : lamps

  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk) sweep_step <= 1'b1;
      @(posedge core_clk) sweep_step <= 1'b0;
    end
  endtask : step

  // Span x n/m + min - span x deviation, mHz, deviation in 0.01 %
  function automatic logic [31:0] exp_freq(longint fmin, longint fmax, longint n, longint m,
                                           longint d);
    longint sp;
    sp = fmax - fmin;
    return 32'(sp * n / m + fmin - sp * d / 10000);
  endfunction : exp_freq

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'hce4eb557));
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk_bit(led_off, 1'b1, "red lamp after reset");
    chk_word({28'h0, den_save}, 32'h9, "den saved");
    rd_chk(mcd_pkg::A_DEN, 32'h9, "den restored");
    rd_chk(mcd_pkg::A_NUM, 32'h9, "num restored");
    rd_chk(mcd_pkg::A_PSET, 32'h1, "default preset");
    P.wr_reg(mcd_pkg::A_FMIN, 32'h0001_1170);
    rd_chk(mcd_pkg::A_FMIN, 32'h0000_afc8, "min above max");
    // Every denominator code, refused ones included
    P.wr_reg(mcd_pkg::A_PSET, 32'h0);
    den = 9;
    for (int i = 0; i < 16; i++) begin
      P.wr_reg(mcd_pkg::A_DEV, 32'h37);
      P.wr_reg(mcd_pkg::A_DEN, 32'(i));
      if (i >= 4) den = i;
      rd_chk(mcd_pkg::A_DEN, 32'(den), "den");
      rd_chk(mcd_pkg::A_NUM, 32'(den), "num load");
      rd_chk(mcd_pkg::A_DEV, (i >= 4) ? 32'h0 : 32'h37, "dev clear");
    end
    repeat (8) begin
      den = 4 + int'($urandom % 12);
      num = int'($urandom % 32'(den + 1));
      dv = int'($urandom % 4001) - 2000;
      P.wr_reg(mcd_pkg::A_DEN, 32'(den));
      P.wr_reg(mcd_pkg::A_NUM, 32'(num));
      P.wr_reg(mcd_pkg::A_DEV, 32'(dv));
      rd_chk(mcd_pkg::A_FOUT, exp_freq(45000, 65000, num, den, dv), "frequency");
      rd_chk(mcd_pkg::A_DEV, 32'(dv), "dev");
    end
    P.wr_reg(mcd_pkg::A_DEV, 32'hffff_f830);
    P.wr_reg(mcd_pkg::A_DEV, 32'h0000_f82f);
    P.wr_reg(mcd_pkg::A_DEV, 32'h0000_07d1);
    rd_chk(mcd_pkg::A_DEV, 32'hffff_f830, "dev limits");
    // Presets against numerator direction
    P.wr_reg(mcd_pkg::A_DEN, 32'h8);
    P.wr_reg(mcd_pkg::A_PSET, 32'h2);
    rd_chk(mcd_pkg::A_DEV, 32'h0000_00c8, "preset 2 select");
    P.wr_reg(mcd_pkg::A_NUM, 32'h5);
    rd_chk(mcd_pkg::A_DEV, 32'hffff_ff38, "preset 2 down");
    P.wr_reg(mcd_pkg::A_NUM, 32'h6);
    rd_chk(mcd_pkg::A_DEV, 32'h0000_00c8, "preset 2 up");
    P.wr_reg(mcd_pkg::A_PSET, 32'h3);
    rd_chk(mcd_pkg::A_DEV, 32'h0000_01f4, "preset 5 select");
    P.wr_reg(mcd_pkg::A_NUM, 32'h2);
    rd_chk(mcd_pkg::A_DEV, 32'hffff_fe0c, "preset 5 down");
    P.wr_reg(mcd_pkg::A_DEN, 32'h7);
    rd_chk(mcd_pkg::A_DEV, 32'h0, "den clears with preset");
    P.wr_reg(mcd_pkg::A_NUM, 32'h8);
    rd_chk(mcd_pkg::A_NUM, 32'h7, "num above den");
    P.wr_reg(mcd_pkg::A_PSET, 32'h1);
    P.wr_reg(mcd_pkg::A_DEV, 32'h4d);
    P.wr_reg(mcd_pkg::A_NUM, 32'h3);
    rd_chk(mcd_pkg::A_DEV, 32'h0, "preset 0 num");
    P.wr_reg(mcd_pkg::A_PSET, 32'h0);
    P.wr_reg(mcd_pkg::A_DEV, 32'h4d);
    P.wr_reg(mcd_pkg::A_NUM, 32'h4);
    rd_chk(mcd_pkg::A_DEV, 32'h4d, "preset off keeps");
    P.wr_reg(mcd_pkg::A_PSW, 32'h2);
    rd_chk(mcd_pkg::A_DEV, 32'h0, "down from off");
    // Output switch, range change, overload, display refresh
    P.wr_reg(mcd_pkg::A_CTRL, 32'h3);
    lamps(1'b1);
    P.wr_reg(mcd_pkg::A_CTRL, 32'h3);
    lamps(1'b0);
    P.wr_reg(mcd_pkg::A_CTRL, 32'h3);
    P.wr_reg(mcd_pkg::A_RANGE, 32'h4);
    lamps(1'b0);
    P.wr_reg(mcd_pkg::A_CTRL, 32'h3);
    repeat (7) @(posedge core_clk);
    #1 chk_word({12'h000, disp_freq}, 32'h0, "display before period");
    @(posedge core_clk);
    #1 chk_word({12'h000, disp_freq}, exp_freq(45000, 65000, 4, 7, 0), "display");
    @(posedge core_clk) ovl_det <= 1'b1;
    @(posedge core_clk) ovl_det <= 1'b0;
    lamps(1'b0);
    chk_bit(err_flag, 1'b1, "error latched");
    chk_word({24'h0, err_code}, {24'h0, ERR}, "error code");
    P.wr_reg(mcd_pkg::A_CTRL, 32'h6);
    lamps(1'b0);
    chk_bit(err_flag, 1'b0, "error cleared");
    // Level clamp and beep on the 300 V range
    P.wr_reg(mcd_pkg::A_DEV, 32'h96);
    P.wr_reg(mcd_pkg::A_LVL, 32'h1388);
    #1 chk_bit(beep_req, 1'b1, "beep at 150 V");
    rd_chk(mcd_pkg::A_DEV, 32'h0, "level clears dev");
    P.wr_reg(mcd_pkg::A_LVL, 32'h1387);
    #1 chk_bit(beep_req, 1'b0, "no beep below");
    P.wr_reg(mcd_pkg::A_LVL, 32'h32c8);
    rd_chk(mcd_pkg::A_LVL, 32'h2ee0, "level clamp");
    P.wr_reg(mcd_pkg::A_CTRL, 32'h0);
    P.wr_reg(mcd_pkg::A_LVL, 32'h1388);
    #1 chk_bit(beep_req, 1'b0, "beep disabled");
    P.wr_reg(mcd_pkg::A_CTRL, 32'h2);
    // Output at the 1000 Hz edge
    P.wr_reg(mcd_pkg::A_FMAX, 32'h000f_4240);
    P.wr_reg(mcd_pkg::A_FMIN, 32'h000f_1b30);
    P.wr_reg(mcd_pkg::A_NUM, 32'h7);
    repeat (3) @(posedge core_clk);
    #1 chk_bit(blink, 1'b1, "blink at limit");
    P.wr_reg(mcd_pkg::A_DEV, 32'h1);
    P.wr_reg(mcd_pkg::A_DEV, 32'hffff_fffb);
    rd_chk(mcd_pkg::A_DEV, 32'h1, "dev to 1000 Hz");
    repeat (3) @(posedge core_clk);
    #1 chk_bit(blink, 1'b0, "blink gone");
    P.wr_reg(mcd_pkg::A_FMIN, 32'h0000_afc8);
    P.wr_reg(mcd_pkg::A_FMAX, 32'h0000_fde8);
    // Sweeps: locked settings, stop at limits, hold
    P.wr_reg(mcd_pkg::A_DEV, 32'hffff_f832);
    P.wr_reg(mcd_pkg::A_SWEEP, 32'h1);
    P.wr_reg(mcd_pkg::A_DEV, 32'h0);
    P.wr_reg(mcd_pkg::A_PSET, 32'h3);
    rd_chk(mcd_pkg::A_DEV, 32'hffff_f832, "dev locked");
    rd_chk(mcd_pkg::A_PSET, 32'h0, "preset locked");
    step(3);
    rd_chk(mcd_pkg::A_DEV, 32'hffff_f830, "up stop dev");
    rd_chk(mcd_pkg::A_SWEEP, 32'h0, "up stop");
    P.wr_reg(mcd_pkg::A_DEV, 32'h7cf);
    P.wr_reg(mcd_pkg::A_SWEEP, 32'h2);
    rd_chk(mcd_pkg::A_SWEEP, 32'h2, "down mode");
    step(3);
    rd_chk(mcd_pkg::A_DEV, 32'h7d0, "down stop dev");
    rd_chk(mcd_pkg::A_SWEEP, 32'h0, "down stop");
    P.wr_reg(mcd_pkg::A_SWEEP, 32'h1);
    step(1);
    P.wr_reg(mcd_pkg::A_SWEEP, 32'h0);
    step(2);
    rd_chk(mcd_pkg::A_DEV, 32'h7cf, "hold freezes");
    tally_and_finish();
  end
endmodule : mcd_ctrl_test

//--- verification/mcd_panel.sv
/*
  Model of the operator side: the front panel or remote command parser
  that reads and writes the controller's settings.
  Assumes the controller takes strobes at the rising edge of core_clk and
  answers a read in the cycle after the strobe, never stalling.
*/
module mcd_panel (
  // Clock
  input wire logic core_clk,
  // Register port toward the controller
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Idle bus shows inverted values so stale data never looks valid
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : mcd_panel
